// File: include/stb_consts.vh
// Constants of the scan test bus transceiver
`ifndef STB_CONSTS_VH
`define STB_CONSTS_VH

// ----------------------------------------------------------------
// Register lengths
// ----------------------------------------------------------------
`define STB_IR_W        8
`define STB_BSR_W       44
`define STB_BCR_W       3
`define STB_ID_W        32
`define STB_SEC_W       9

// ----------------------------------------------------------------
// Reset and capture values
// ----------------------------------------------------------------
`define STB_IR_RESET    8'h81
`define STB_IR_CAPTURE  8'h81
`define STB_BCR_RESET   3'h2

// ----------------------------------------------------------------
// Opcodes, all of even parity
// ----------------------------------------------------------------
`define STB_OP_EXTEST   8'h00
`define STB_OP_SAMPLE   8'h82
`define STB_OP_IDCODE   8'h81
`define STB_OP_BYPASS   8'hff
`define STB_OP_FLOAT_OUTPUTS_INSTR    8'h06
`define STB_OP_CLAMP    8'h87
`define STB_OP_RUNT     8'h09
`define STB_OP_SCANCN   8'h0a

// ----------------------------------------------------------------
// Boundary-control operations
// ----------------------------------------------------------------
`define STB_BC_TOGGLE   3'h0
`define STB_BC_PSEUDO_RANDOM_PATTERN_GEN     3'h1
`define STB_BC_PSA      3'h2
`define STB_BC_COUNT    3'h3

// ----------------------------------------------------------------
// Boundary cell positions
// ----------------------------------------------------------------
`define STB_BSR_B1      0
`define STB_BSR_B2      9
`define STB_BSR_A1      18
`define STB_BSR_A2      27
`define STB_BSR_DIR1    36
`define STB_BSR_DIR2    37
`define STB_BSR_OEN1    38
`define STB_BSR_OEN2    39
`define STB_BSR_EB1     40
`define STB_BSR_EA1     41
`define STB_BSR_EB2     42
`define STB_BSR_EA2     43

`endif

// File: rtl/stb_scan_xcvr.v
// Scan test bus transceiver: two 9-bit sections with boundary-scan test logic
`timescale 1ns/1ps
`default_nettype none
`include "stb_consts.vh"

// Overview of operation
// - Normal mode passes data uninverted A<->B, as two 9-bit or one 18-bit transceiver.
// - Each section has its own direction and output-enable inputs.
// - Enable low: direction low drives B onto A, high drives A onto B.
// - Enable high isolates the section, neither port driven.
// - TAP activity in normal mode leaves the data path unchanged.
// - Normal mode allows sampling pins without disturbing data; boundary self-test runs in test mode.
// - Test mode overrides the transceiver; boundary cells observe and control pins.
// - Test inputs sampled on test-clock rise, test output changes on fall.
// - Test-mode-select alone steers the TAP state machine.
// - Test data input feeds the instruction or selected data register.
// - Test data output presents that register's serial output while shifting.
// - Undriven test data input and mode select read as high.
// - Instruction register is 8 bits.
// - 44-cell boundary register and 3-bit boundary-control register selectable.
// - One-bit bypass and 32-bit identification registers.
// - Signature analysis on inputs, pseudo-random patterns on outputs.
// - Standard, clamp, float, toggle, count and identify instructions, even parity.
// - Reset state loads instruction 10000001 and boundary control 010.
// - Mode select held high reaches reset state within five test clocks.
// - Reset clears boundary cells 43 to 40, floating test-mode outputs.
// - Test output enables on first fall in shift, floats on first fall in exit.

module stb_scan_xcvr #(
  parameter [31:0] ID_CODE = 32'h0000_5a01  // Arbitrary identification value
) (
  input  wire                 clk_i,
  input  wire                 rst_i,
  input  wire                 ce_i,
  input  wire                 tck_i,
  input  wire                 tms_i,
  input  wire                 tdi_i,
  output reg                  tdo_o,
  output reg                  tdo_oe_o,
  input  wire                 sec1_dir_ctl_i,
  input  wire                 sec2_dir_ctl_i,
  input  wire                 sec1_out_en_n_i,
  input  wire                 sec2_out_en_n_i,
  input  wire [8:0]           sec1_a_port_i,
  output wire [8:0]           sec1_a_port_o,
  output wire [8:0]           sec1_a_port_oe_o,
  input  wire [8:0]           sec1_b_port_i,
  output wire [8:0]           sec1_b_port_o,
  output wire [8:0]           sec1_b_port_oe_o,
  input  wire [8:0]           sec2_a_port_i,
  output wire [8:0]           sec2_a_port_o,
  output wire [8:0]           sec2_a_port_oe_o,
  input  wire [8:0]           sec2_b_port_i,
  output wire [8:0]           sec2_b_port_o,
  output wire [8:0]           sec2_b_port_oe_o
);

  // ----------------------------------------------------------------
  // TAP states
  // ----------------------------------------------------------------
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDS = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PD  = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UPD = 16'h0100;
  localparam [15:0] S_SIS = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PI  = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UPI = 16'h8000;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [15:0] tap_next;
    input [15:0] s;
    input        m;
    begin
      case (s)
        S_TLR:   tap_next = m ? S_TLR : S_RTI;
        S_RTI:   tap_next = m ? S_SDS : S_RTI;
        S_SDS:   tap_next = m ? S_SIS : S_CDR;
        S_CDR:   tap_next = m ? S_E1D : S_SHD;
        S_SHD:   tap_next = m ? S_E1D : S_SHD;
        S_E1D:   tap_next = m ? S_UPD : S_PD;
        S_PD:    tap_next = m ? S_E2D : S_PD;
        S_E2D:   tap_next = m ? S_UPD : S_SHD;
        S_UPD:   tap_next = m ? S_SDS : S_RTI;
        S_SIS:   tap_next = m ? S_TLR : S_CIR;
        S_CIR:   tap_next = m ? S_E1I : S_SHI;
        S_SHI:   tap_next = m ? S_E1I : S_SHI;
        S_E1I:   tap_next = m ? S_UPI : S_PI;
        S_PI:    tap_next = m ? S_E2I : S_PI;
        S_E2I:   tap_next = m ? S_UPI : S_SHI;
        S_UPI:   tap_next = m ? S_SDS : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  // Maximal-length x^18 + x^11 + 1 step, shared by signature and pattern modes
  function [17:0] lfsr18;
    input [17:0] x;
    begin
      lfsr18 = {x[16:0], x[17] ^ x[10]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [2:0]  tap_s1_q;
  reg  [2:0]  tap_s2_q;
  reg         tck_d3_q;
  reg  [39:0] pin_s1_q;
  reg  [39:0] pin_s2_q;
  wire [39:0] pin_raw;
  wire        tck_s;
  wire        tms_s;
  wire        tdi_s;
  wire        tck_rise;
  wire        tck_fall;

  assign pin_raw = {sec2_out_en_n_i, sec1_out_en_n_i, sec2_dir_ctl_i, sec1_dir_ctl_i,
                    sec2_a_port_i, sec1_a_port_i, sec2_b_port_i, sec1_b_port_i};

  always @(posedge clk_i) begin
    if (rst_i) begin
      tap_s1_q <= 3'h6;
      tap_s2_q <= 3'h6;
      tck_d3_q <= 1'b0;
      pin_s1_q <= 40'h00_0000_0000;
      pin_s2_q <= 40'h00_0000_0000;
    end else if (ce_i) begin
      tap_s1_q <= {tms_i, tdi_i, tck_i};
      tap_s2_q <= tap_s1_q;
      tck_d3_q <= tap_s2_q[0];
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign tck_s    = tap_s2_q[0];
  assign tdi_s    = tap_s2_q[1];
  assign tms_s    = tap_s2_q[2];
  assign tck_rise = ce_i & tck_s & ~tck_d3_q;
  assign tck_fall = ce_i & ~tck_s & tck_d3_q;

  // ----------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------
  reg  [15:0] state_q;

  // Five rises with mode select high always land in reset from any state
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_TLR;
    end else if (tck_rise) begin
      state_q <= tap_next(state_q, tms_s);
    end
  end

  // ----------------------------------------------------------------
  // Test registers
  // ----------------------------------------------------------------
  reg  [`STB_IR_W-1:0]  ir_sh_q;
  reg  [`STB_IR_W-1:0]  ir_q;
  reg  [`STB_BSR_W-1:0] bsr_sh_q;
  reg  [`STB_BSR_W-1:0] bsr_up_q;
  reg  [`STB_BCR_W-1:0] bcr_sh_q;
  reg  [`STB_BCR_W-1:0] bcr_q;
  reg                   byp_q;
  reg  [`STB_ID_W-1:0]  id_sh_q;
  reg                   sel_bsr;
  reg                   sel_bcr;
  reg                   sel_id;
  reg                   test_mode;
  reg                   float_outputs_instr;
  reg                   dr_lsb;
  wire                  in_shd;
  wire                  in_shi;
  wire [17:0]           b_cells;
  wire [17:0]           a_cells;

  assign in_shd  = (state_q == S_SHD);
  assign in_shi  = (state_q == S_SHI);
  assign b_cells = bsr_up_q[`STB_BSR_A1-1:`STB_BSR_B1];
  assign a_cells = bsr_up_q[`STB_BSR_DIR1-1:`STB_BSR_A1];

  // Unknown opcodes fall back to bypass so a chain never breaks
  always @* begin
    sel_bsr             = 1'b0;
    sel_bcr             = 1'b0;
    sel_id              = 1'b0;
    test_mode           = 1'b0;
    float_outputs_instr = 1'b0;
    case (ir_q)
      `STB_OP_EXTEST: begin
        sel_bsr   = 1'b1;
        test_mode = 1'b1;
      end
      `STB_OP_SAMPLE: sel_bsr = 1'b1;
      `STB_OP_IDCODE: sel_id = 1'b1;
      `STB_OP_SCANCN: sel_bcr = 1'b1;
      `STB_OP_FLOAT_OUTPUTS_INSTR: begin
        test_mode           = 1'b1;
        float_outputs_instr = 1'b1;
      end
      `STB_OP_CLAMP: test_mode = 1'b1;
      `STB_OP_RUNT:  test_mode = 1'b1;
      default: sel_bsr = 1'b0;
    endcase
  end

  always @* begin
    if (sel_bsr) begin
      dr_lsb = bsr_sh_q[0];
    end else if (sel_bcr) begin
      dr_lsb = bcr_sh_q[0];
    end else if (sel_id) begin
      dr_lsb = id_sh_q[0];
    end else begin
      dr_lsb = byp_q;
    end
  end

  // Capture and shift on the rising edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      ir_sh_q  <= `STB_IR_RESET;
      bsr_sh_q <= {`STB_BSR_W{1'b0}};
      bcr_sh_q <= `STB_BCR_RESET;
      byp_q    <= 1'b0;
      id_sh_q  <= ID_CODE;
    end else if (tck_rise) begin
      if (state_q == S_CIR) begin
        ir_sh_q <= `STB_IR_CAPTURE;
      end else if (in_shi) begin
        ir_sh_q <= {tdi_s, ir_sh_q[`STB_IR_W-1:1]};
      end
      if (state_q == S_CDR) begin
        bsr_sh_q <= {bsr_up_q[`STB_BSR_W-1:`STB_BSR_EB1], pin_s2_q};
        bcr_sh_q <= bcr_q;
        byp_q    <= 1'b0;
        id_sh_q  <= ID_CODE;
      end else if (in_shd) begin
        if (sel_bsr) begin
          bsr_sh_q <= {tdi_s, bsr_sh_q[`STB_BSR_W-1:1]};
        end else if (sel_bcr) begin
          bcr_sh_q <= {tdi_s, bcr_sh_q[`STB_BCR_W-1:1]};
        end else if (sel_id) begin
          id_sh_q <= {tdi_s, id_sh_q[`STB_ID_W-1:1]};
        end else begin
          byp_q <= tdi_s;
        end
      end
    end
  end

  // Instruction and boundary-control shadows
  always @(posedge clk_i) begin
    if (rst_i) begin
      ir_q  <= `STB_IR_RESET;
      bcr_q <= `STB_BCR_RESET;
    end else if (ce_i && state_q == S_TLR) begin
      ir_q  <= `STB_IR_RESET;
      bcr_q <= `STB_BCR_RESET;
    end else if (tck_fall) begin
      if (state_q == S_UPI) begin
        ir_q <= ir_sh_q;
      end
      if (state_q == S_UPD && sel_bcr) begin
        bcr_q <= bcr_sh_q;
      end
    end
  end

  // Boundary update cells; self-test runs in Run-Test/Idle on each rise
  always @(posedge clk_i) begin
    if (rst_i) begin
      bsr_up_q <= {`STB_BSR_W{1'b0}};
    end else if (ce_i && state_q == S_TLR) begin
      bsr_up_q[`STB_BSR_W-1:`STB_BSR_EB1] <= 4'h0;
    end else if (tck_fall && state_q == S_UPD && sel_bsr) begin
      bsr_up_q <= bsr_sh_q;
    end else if (tck_rise && state_q == S_RTI && ir_q == `STB_OP_RUNT) begin
      case (bcr_q)
        `STB_BC_PSA:
          bsr_up_q[`STB_BSR_DIR1-1:`STB_BSR_A1] <=
            lfsr18(a_cells) ^ pin_s2_q[`STB_BSR_DIR1-1:`STB_BSR_A1];
        `STB_BC_PSEUDO_RANDOM_PATTERN_GEN:
          bsr_up_q[`STB_BSR_A1-1:`STB_BSR_B1] <= lfsr18(b_cells);
        `STB_BC_COUNT:
          bsr_up_q[`STB_BSR_A1-1:`STB_BSR_B1] <= b_cells + 18'h00001;
        `STB_BC_TOGGLE: begin
          bsr_up_q[`STB_BSR_A1-1:`STB_BSR_B1]   <= ~b_cells;
          bsr_up_q[`STB_BSR_DIR1-1:`STB_BSR_A1] <=
            pin_s2_q[`STB_BSR_DIR1-1:`STB_BSR_A1];
        end
        default: bsr_up_q <= bsr_up_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Test data output, changed only on falling edges
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_o <= in_shi | in_shd;
      tdo_o    <= in_shi ? ir_sh_q[0] : dr_lsb;
    end
  end

  // ----------------------------------------------------------------
  // Transceiver data path
  // ----------------------------------------------------------------
  // Normal mode is pure gating on the pins so the test clock never adds latency
  wire       n1_en;
  wire       n2_en;
  wire [8:0] t1_a_en;
  wire [8:0] t1_b_en;
  wire [8:0] t2_a_en;
  wire [8:0] t2_b_en;

  assign n1_en   = ~sec1_out_en_n_i;
  assign n2_en   = ~sec2_out_en_n_i;
  assign t1_a_en = {9{bsr_up_q[`STB_BSR_EA1] & ~float_outputs_instr}};
  assign t1_b_en = {9{bsr_up_q[`STB_BSR_EB1] & ~float_outputs_instr}};
  assign t2_a_en = {9{bsr_up_q[`STB_BSR_EA2] & ~float_outputs_instr}};
  assign t2_b_en = {9{bsr_up_q[`STB_BSR_EB2] & ~float_outputs_instr}};

  assign sec1_a_port_o    = test_mode ? a_cells[8:0]  : sec1_b_port_i;
  assign sec1_b_port_o    = test_mode ? b_cells[8:0]  : sec1_a_port_i;
  assign sec2_a_port_o    = test_mode ? a_cells[17:9] : sec2_b_port_i;
  assign sec2_b_port_o    = test_mode ? b_cells[17:9] : sec2_a_port_i;
  assign sec1_a_port_oe_o = test_mode ? t1_a_en : {9{n1_en & ~sec1_dir_ctl_i}};
  assign sec1_b_port_oe_o = test_mode ? t1_b_en : {9{n1_en & sec1_dir_ctl_i}};
  assign sec2_a_port_oe_o = test_mode ? t2_a_en : {9{n2_en & ~sec2_dir_ctl_i}};
  assign sec2_b_port_oe_o = test_mode ? t2_b_en : {9{n2_en & sec2_dir_ctl_i}};

endmodule // stb_scan_xcvr

`default_nettype wire

// File: test/stb_scan_xcvr_checker.sv
// Checker of the scan test bus transceiver ports
`timescale 1ns/1ps
`default_nettype none

module stb_scan_xcvr_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       tck_i,
  input wire logic       tms_i,
  input wire logic       tdo_o,
  input wire logic       tdo_oe_o,
  input wire logic       sec1_dir_ctl_i,
  input wire logic       sec2_dir_ctl_i,
  input wire logic       sec1_out_en_n_i,
  input wire logic       sec2_out_en_n_i,
  input wire logic [8:0] sec1_a_port_i,
  input wire logic [8:0] sec1_b_port_i,
  input wire logic [8:0] sec1_a_port_o,
  input wire logic [8:0] sec1_b_port_o,
  input wire logic [8:0] sec1_a_port_oe_o,
  input wire logic [8:0] sec1_b_port_oe_o,
  input wire logic [8:0] sec2_a_port_oe_o,
  input wire logic [8:0] sec2_b_port_oe_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Idle means no test clock seen since reset, so normal mode is certain
  logic       idle_q;
  logic       tck_q;
  logic [3:0] fall_q;
  logic [2:0] ones_q;
  always_ff @(posedge clk_i) begin
    tck_q <= tck_i;
    if (rst_i) begin
      idle_q <= 1'b1;
      fall_q <= 4'hf;
      ones_q <= 3'h0;
    end else begin
      if (tck_i)
        idle_q <= 1'b0;
      if (tck_q && !tck_i)
        fall_q <= 4'h0;
      else if (fall_q != 4'hf)
        fall_q <= fall_q + 4'h1;
      if (!tck_q && tck_i)
        ones_q <= !tms_i ? 3'h0 : (ones_q == 3'h7) ? ones_q : ones_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sec1_a_en_a: assert property (idle_q |->
    sec1_a_port_oe_o == {9{!sec1_out_en_n_i && !sec1_dir_ctl_i}}) else $error("sec1 A enable");
  sec1_b_en_a: assert property (idle_q |->
    sec1_b_port_oe_o == {9{!sec1_out_en_n_i && sec1_dir_ctl_i}}) else $error("sec1 B enable");
  sec1_ab_a: assert property (idle_q && sec1_dir_ctl_i |->
    sec1_b_port_o == sec1_a_port_i) else $error("sec1 A to B data");
  sec1_ba_a: assert property (idle_q && !sec1_dir_ctl_i |->
    sec1_a_port_o == sec1_b_port_i) else $error("sec1 B to A data");
  sec2_en_a: assert property (idle_q |-> {sec2_a_port_oe_o, sec2_b_port_oe_o} ==
    {{9{!sec2_out_en_n_i && !sec2_dir_ctl_i}}, {9{!sec2_out_en_n_i && sec2_dir_ctl_i}}})
    else $error("sec2 enables");
  tdo_quiet_a: assert property (idle_q |-> !tdo_oe_o) else $error("tdo driven idle");
  tdo_fall_a: assert property ($changed(tdo_o) |->
    fall_q >= 4'h1 && fall_q <= 4'h5) else $error("tdo off fall");
  tdo_en_fall_a: assert property ($changed(tdo_oe_o) |->
    fall_q >= 4'h1 && fall_q <= 4'h5) else $error("tdo enable off fall");
  five_ones_a: assert property (ones_q >= 3'h5 |-> !tdo_oe_o) else $error("no reset");

  cover property (idle_q && sec1_dir_ctl_i && !sec1_out_en_n_i);
  cover property ($rose(tdo_oe_o));
  cover property (ones_q == 3'h5);
endmodule // stb_scan_xcvr_checker

bind stb_scan_xcvr stb_scan_xcvr_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck_i),
  .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .sec1_dir_ctl_i(sec1_dir_ctl_i),
  .sec2_dir_ctl_i(sec2_dir_ctl_i), .sec1_out_en_n_i(sec1_out_en_n_i),
  .sec2_out_en_n_i(sec2_out_en_n_i), .sec1_a_port_i(sec1_a_port_i),
  .sec1_b_port_i(sec1_b_port_i), .sec1_a_port_o(sec1_a_port_o), .sec1_b_port_o(sec1_b_port_o),
  .sec1_a_port_oe_o(sec1_a_port_oe_o), .sec1_b_port_oe_o(sec1_b_port_oe_o),
  .sec2_a_port_oe_o(sec2_a_port_oe_o), .sec2_b_port_oe_o(sec2_b_port_oe_o));
`default_nettype wire

// File: test/stb_tap_model.sv
// Test controller model driving the four-wire test port
`timescale 1ns/1ps
`default_nettype none

module stb_tap_model (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output var logic  tck_o,
  output var logic  tms_o,
  output var logic  tdi_o
);
  logic frame_ok;
  // Pull-up level while nothing drives the mode and data lines
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // ----------------------------------------------------------------
  // One 80 ns test-clock period; tdo sampled midway through the high phase, before the fall
  // ----------------------------------------------------------------
  task automatic step(input logic m, input logic d, output logic q, output logic e);
    @(posedge clk_i);
    tms_o <= m;
    tdi_o <= d;
    repeat (3) @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    // A released line shows the inverse, so a late or early enable corrupts the bit
    q = tdo_oe_i ? tdo_i : ~tdo_i;
    e = tdo_oe_i;
    repeat (2) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask
  task automatic go_idle();
    logic q, e;
    step(1'b0, 1'b1, q, e);
  endtask
  // Scan from idle back to idle, least significant bit first
  task automatic scan(input logic ir, input int n, input logic [43:0] din,
                      output logic [43:0] dout);
    logic q, e;
    dout = '0;
    frame_ok = 1'b1;
    step(1'b1, 1'b1, q, e);
    if (ir)
      step(1'b1, 1'b1, q, e);
    step(1'b0, 1'b1, q, e);
    step(1'b0, 1'b1, q, e);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, e);
      dout[i] = q;
      frame_ok = frame_ok & e;
    end
    step(1'b1, 1'b1, q, e);
    frame_ok = frame_ok & ~e;
    go_idle();
  endtask
endmodule // stb_tap_model
`default_nettype wire

// File: test/stb_scan_xcvr_bench.sv
// Testbench of the scan test bus transceiver
`timescale 1ns/1ps
`default_nettype none

module stb_scan_xcvr_bench;
  localparam logic [31:0] ID_VAL = 32'h3c5a_0e01; // Arbitrary identification value
  logic        clk_i, rst_i, dir1, dir2, oen1, oen2;
  logic [8:0]  a1d, b1d, a2d, b2d;
  logic [43:0] sh_out;
  wire         tck, tms, tdi, tdo, tdo_oe;
  wire  [8:0]  a1, b1, a2, b2, a1o, b1o, a2o, b2o, a1e, b1e, a2e, b2e;
  int          err_total = 0;
  int          n_tests = 0;
  // Pin level: the transceiver where it drives, the board elsewhere
  assign a1 = (a1e & a1o) | (~a1e & a1d);
  assign b1 = (b1e & b1o) | (~b1e & b1d);
  assign a2 = (a2e & a2o) | (~a2e & a2d);
  assign b2 = (b2e & b2o) | (~b2e & b2d);

  stb_scan_xcvr #(.ID_CODE(ID_VAL)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .sec1_dir_ctl_i(dir1), .sec2_dir_ctl_i(dir2), .sec1_out_en_n_i(oen1),
    .sec2_out_en_n_i(oen2), .sec1_a_port_i(a1), .sec1_a_port_o(a1o), .sec1_a_port_oe_o(a1e),
    .sec1_b_port_i(b1), .sec1_b_port_o(b1o), .sec1_b_port_oe_o(b1e), .sec2_a_port_i(a2),
    .sec2_a_port_o(a2o), .sec2_a_port_oe_o(a2e), .sec2_b_port_i(b2), .sec2_b_port_o(b2o),
    .sec2_b_port_oe_o(b2e));
  stb_tap_model u_tap (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic sc(input logic ir, input int n, input logic [43:0] din);
    u_tap.scan(ir, n, din, sh_out);
    cmp(u_tap.frame_ok, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_normal();
    logic [8:0] v;
    logic ea1, eb1, ea2, eb2;
    for (int k = 0; k < 16; k++) begin
      v = k[8:0];
      @(posedge clk_i);
      {dir1, oen1, dir2, oen2} <= k[3:0];
      {a1d, b1d, a2d, b2d} <= {v ^ 9'h0a5, v ^ 9'h13c, ~v, v ^ 9'h1c3};
      repeat (2) @(posedge clk_i);
      {ea1, eb1, ea2, eb2} = {~oen1 & ~dir1, ~oen1 & dir1, ~oen2 & ~dir2, ~oen2 & dir2};
      cmp({a1e, b1e, a2e, b2e}, {{9{ea1}}, {9{eb1}}, {9{ea2}}, {9{eb2}}});
      cmp({a1, b1, a2, b2}, {ea1 ? b1d : a1d, eb1 ? a1d : b1d,
        ea2 ? b2d : a2d, eb2 ? a2d : b2d});
    end
  endtask
  task automatic t_bypass();
    sc(1'b1, 8, 44'hff);
    cmp(sh_out[7:0], 8'h81);
    sc(1'b0, 9, 44'h1a5);
    cmp(sh_out[8:0], 9'h14a);
  endtask
  task automatic t_sample();
    @(posedge clk_i);
    {dir1, dir2, oen1, oen2} <= 4'h8;
    {a1d, b1d, a2d, b2d} <= {9'h12d, 9'h0f6, 9'h071, 9'h0b3};
    sc(1'b1, 8, 44'h82);
    cmp(sh_out[7:0], 8'h81);
    sc(1'b0, 44, 44'h0_5a5a5a5a5);
    cmp(sh_out, {4'h0, 4'h1, 9'h0b3, 9'h12d, 9'h0b3, 9'h12d});
    cmp({a1, b1, a2, b2}, {9'h12d, 9'h12d, 9'h0b3, 9'h0b3});
  endtask
  task automatic t_test_mode();
    sc(1'b1, 8, 44'h00);
    cmp({a1e, b1e, a2e, b2e}, 36'h0);
    sc(1'b0, 44, {4'hf, 4'h0, 9'h0c3, 9'h111, 9'h1f0, 9'h02d});
    cmp(sh_out, {4'h0, 4'h1, 9'h071, 9'h12d, 9'h0b3, 9'h0f6});
    cmp({a1o, b1o, a2o, b2o, a1e, b1e, a2e, b2e},
      {9'h111, 9'h02d, 9'h0c3, 9'h1f0, 36'hf_ffff_ffff});
    sc(1'b1, 8, 44'h06);
    cmp({a1e, b1e, a2e, b2e}, 36'h0);
    sc(1'b1, 8, 44'h0a);
    sc(1'b0, 6, 44'h2b);
    cmp(sh_out[5:0], 6'h1a);
  endtask
  // Abandon a data scan midway; five high mode-select clocks must recover
  task automatic t_reset();
    logic q, e;
    u_tap.step(1'b1, 1'b1, q, e);
    u_tap.step(1'b0, 1'b1, q, e);
    u_tap.step(1'b0, 1'b1, q, e);
    repeat (5) u_tap.step(1'b1, 1'b1, q, e);
    u_tap.go_idle();
    cmp({a1e, b1e, a2e, b2e}, {9'h0, 9'h1ff, 9'h1ff, 9'h0});
    sc(1'b0, 32, 44'h0);
    cmp(sh_out[31:0], ID_VAL);
  endtask
  // Self-test ops run once per test-clock rise in Run-Test/Idle, the rise that
  // opens the next scan included; clamp then holds the cells still
  task automatic t_selftest();
    logic [17:0] x;
    sc(1'b1, 8, 44'h0a);
    sc(1'b0, 3, 44'h3);
    cmp(sh_out[2:0], 3'h2);
    sc(1'b1, 8, 44'h09);
    repeat (3) u_tap.go_idle();
    cmp({b2o, b1o, a1e, b1e, a2e, b2e}, {9'h1f0, 9'h030, 36'h0});
    sc(1'b1, 8, 44'h0a);
    sc(1'b0, 3, 44'h1);
    cmp(sh_out[2:0], 3'h3);
    x = {9'h1f0, 9'h031};
    x = {x[16:0], x[17] ^ x[10]};
    sc(1'b1, 8, 44'h09);
    u_tap.go_idle();
    cmp({b2o, b1o}, x);
    x = {x[16:0], x[17] ^ x[10]};
    sc(1'b1, 8, 44'h87);
    repeat (2) u_tap.go_idle();
    cmp({b2o, b1o, a1e, b2e}, {x, 18'h0});
    sc(1'b0, 2, 44'h1);
    cmp(sh_out[1:0], 2'h2);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {dir1, dir2, oen1, oen2} = 4'h3;
    {a1d, b1d, a2d, b2d} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_normal();
    u_tap.go_idle();
    t_bypass();
    t_sample();
    t_test_mode();
    t_reset();
    t_selftest();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
endmodule // stb_scan_xcvr_bench
`default_nettype wire
